// file: src/sibf_frontend.sv
// Operation
// [R1] sample data on rising clock edge
// [R2] controller changes data only after falling edge
// [R3] present read bit after fall, hold
// [R4] controller drives lines low only
// [R5] any slow or paused clock works
// [R6] wait fifteen ms before accepting commands
// [R7] idle enters sleep automatically
// [R8] transactions open with start, close stop
// [R9] data fall while clock high: start
// [R10] data rise while clock high: stop
// [R11] busy from start until stop
// [R12] all instances share one address
// [R13] header: address 1000000 plus direction
// [R14] acknowledge byte after eighth falling edge
// [R15] pads open drain low only
`timescale 1ns/1ns
`default_nettype none
module sibf_frontend
    import sibf_pkg::*;
#(
    parameter int PWRUP_CYC = SIBF_PWRUP_CYC,
    parameter int FIFO_DEPTH = SIBF_FIFO_DEPTH
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    output logic [7:0] rx_data,
    output logic rx_valid,
    input wire logic rx_ready,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready,
    output logic bus_busy,
    output logic dev_ready,
    output logic sleeping,
    output logic start_seen,
    output logic stop_seen
);
    localparam int CW = $clog2(PWRUP_CYC + 1);
    // two stage synchronisers; stage one read only by stage two
    logic scl_m_q, scl_s_q, sda_m_q, sda_s_q;
    logic scl_p_q, sda_p_q; // previous synced values for edges
    logic scl_rise, scl_fall, st_cond, sp_cond;
    sibf_state_t st_q, st_d; // protocol state
    logic [CW-1:0] pw_q, pw_d; // power-up counter
    logic [3:0] bit_q, bit_d; // bit counter within byte
    logic [7:0] sh_q, sh_d; // shift register
    logic hdr_q, hdr_d; // next byte is a header
    logic busy_q, busy_d; // bus occupied
    logic sda_lo_q, sda_lo_d; // pull data low
    logic push; // byte to fifo
    logic nak_q, nak_d; // read header acked, or controller refused our byte
    sibf_stream_if #(.W(8)) wr_s ();
    sibf_stream_if #(.W(8)) rd_s ();

    // synchronise the pins into mclk
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            scl_m_q <= 1'b1;
            scl_s_q <= 1'b1;
            sda_m_q <= 1'b1;
            sda_s_q <= 1'b1;
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_m_q <= scl_i;
            scl_s_q <= scl_m_q;
            sda_m_q <= sda_i;
            sda_s_q <= sda_m_q;
            scl_p_q <= scl_s_q;
            sda_p_q <= sda_s_q;
        end
    end

    // edge detection is level based, so a paused clock just waits [R5]
    assign scl_rise = scl_s_q && !scl_p_q;
    assign scl_fall = !scl_s_q && scl_p_q;
    assign st_cond = scl_s_q && scl_p_q && sda_p_q && !sda_s_q; // [R9]
    assign sp_cond = scl_s_q && scl_p_q && !sda_p_q && sda_s_q; // [R10]

    // byte received after the address phase goes into the fifo
    assign wr_s.data = sh_q;
    assign push = (st_q == SIBF_ST_RX) && scl_fall && !hdr_q
        && (bit_q == SIBF_BYTE_BITS);
    assign wr_s.valid = push;
    sibf_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .mclk(mclk),
        .nrst(nrst),
        .wr(wr_s),
        .rd(rd_s)
    );
    assign rx_valid = rd_s.valid;
    assign rx_data = rd_s.data;
    assign rd_s.ready = rx_ready;

    // protocol next state
    always_comb begin
        st_d = st_q;
        pw_d = pw_q;
        bit_d = bit_q;
        sh_d = sh_q;
        hdr_d = hdr_q;
        busy_d = busy_q;
        sda_lo_d = sda_lo_q;
        nak_d = nak_q;
        tx_ready = 1'b0;
        case (st_q)
            SIBF_ST_PWRUP: begin
                // count only while clock line high [R6]
                if (scl_s_q) begin
                    pw_d = pw_q + 1'b1;
                end
                if (pw_q == CW'(PWRUP_CYC)) begin
                    st_d = SIBF_ST_IDLE; // [R6]
                end
            end
            SIBF_ST_RX: begin
                if (scl_rise && bit_q != SIBF_BYTE_BITS) begin
                    sh_d = {sh_q[6:0], sda_s_q}; // [R1]
                    bit_d = bit_q + 1'b1;
                end
                if (scl_fall && bit_q == SIBF_BYTE_BITS) begin
                    bit_d = '0;
                    if (hdr_q && sh_q[7:1] != SIBF_ADDR) begin
                        st_d = SIBF_ST_SKIP; // not us [R12]
                    end else if (!hdr_q && !wr_s.ready) begin
                        st_d = SIBF_ST_SKIP; // fifo full: no ack
                    end else begin
                        sda_lo_d = 1'b1; // ack after eighth fall [R14]
                        st_d = SIBF_ST_ACK;
                        nak_d = hdr_q && (sh_q[0] == SIBF_DIR_READ); // [R13]
                    end
                    hdr_d = 1'b0;
                end
            end
            SIBF_ST_ACK: begin
                if (scl_fall) begin
                    sda_lo_d = 1'b0;
                    if (nak_q) begin
                        // read: present first bit after fall [R3]
                        tx_ready = 1'b1;
                        sh_d = tx_valid ? tx_data : 8'hff;
                        sda_lo_d = tx_valid ? !tx_data[7] : 1'b0;
                        bit_d = 4'h1;
                        st_d = SIBF_ST_TX;
                    end else begin
                        st_d = SIBF_ST_RX;
                    end
                    nak_d = 1'b0;
                end
            end
            SIBF_ST_TX: begin
                // shift on each fall, hold until next fall [R3]
                if (scl_fall) begin
                    if (bit_q == SIBF_BYTE_BITS) begin
                        sda_lo_d = 1'b0;
                        st_d = SIBF_ST_TXACK;
                    end else begin
                        sh_d = {sh_q[6:0], 1'b1};
                        sda_lo_d = !sh_q[6];
                        bit_d = bit_q + 1'b1;
                    end
                end
            end
            SIBF_ST_TXACK: begin
                if (scl_rise) begin
                    nak_d = sda_s_q; // controller ack sampled [R1]
                end
                if (scl_fall) begin
                    if (nak_q) begin
                        st_d = SIBF_ST_SKIP;
                    end else begin
                        tx_ready = 1'b1;
                        sh_d = tx_valid ? tx_data : 8'hff;
                        sda_lo_d = tx_valid ? !tx_data[7] : 1'b0;
                        bit_d = 4'h1;
                        st_d = SIBF_ST_TX;
                    end
                end
            end
            default: begin
                // idle and skip: released until a start; only idle counts as sleeping [R7]
            end
        endcase
        // start and stop override the byte machine once powered up
        if (st_q != SIBF_ST_PWRUP) begin
            if (st_cond) begin
                busy_d = 1'b1; // [R11]
                st_d = SIBF_ST_RX; // new sequence, also repeated start
                bit_d = '0;
                hdr_d = 1'b1;
                sda_lo_d = 1'b0;
                nak_d = 1'b0;
            end else if (sp_cond) begin
                busy_d = 1'b0; // [R11]
                st_d = SIBF_ST_IDLE; // back to sleep [R7]
                sda_lo_d = 1'b0;
            end
        end
    end

    // register protocol state
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            st_q <= SIBF_ST_PWRUP;
            pw_q <= '0;
            bit_q <= '0;
            sh_q <= '0;
            hdr_q <= 1'b0;
            busy_q <= 1'b0;
            sda_lo_q <= 1'b0;
            nak_q <= 1'b0;
        end else begin
            st_q <= st_d;
            pw_q <= pw_d;
            bit_q <= bit_d;
            sh_q <= sh_d;
            hdr_q <= hdr_d;
            busy_q <= busy_d;
            sda_lo_q <= sda_lo_d;
            nak_q <= nak_d;
        end
    end

    // pads: only ever pull low, released otherwise [R15]
    assign sda_o = 1'b0;
    assign sda_oe = sda_lo_q; // [R15]
    assign scl_o = 1'b0;
    assign scl_oe = 1'b0; // no clock stretching in this front end
    assign bus_busy = busy_q;
    assign dev_ready = (st_q != SIBF_ST_PWRUP);
    assign sleeping = (st_q == SIBF_ST_IDLE) && !busy_q; // [R7]
    assign start_seen = st_cond && dev_ready;
    assign stop_seen = sp_cond && dev_ready;
endmodule : sibf_frontend
`default_nettype wire

// file: src/sibf_pkg.sv
package sibf_pkg;
    // fixed target address, seven bits, shared by every instance
    localparam logic [6:0] SIBF_ADDR = 7'h40;
    // direction bit value meaning read
    localparam logic SIBF_DIR_READ = 1'b1;
    // power-up delay before idle, in microseconds, and the derived count
    localparam int SIBF_CLK_MHZ = 125;
    localparam int SIBF_PWRUP_US = 15000;
    localparam int SIBF_PWRUP_CYC = SIBF_PWRUP_US * SIBF_CLK_MHZ;
    // bits in one byte on the wire
    localparam logic [3:0] SIBF_BYTE_BITS = 4'h8;
    // default fifo shape
    localparam int SIBF_FIFO_DEPTH = 8;
    localparam int SIBF_FIFO_WIDTH = 8;
    // front end states
    typedef enum logic [2:0] {
        SIBF_ST_PWRUP, SIBF_ST_IDLE, SIBF_ST_RX, SIBF_ST_ACK,
        SIBF_ST_TX, SIBF_ST_TXACK, SIBF_ST_SKIP
    } sibf_state_t;
endpackage : sibf_pkg

// file: src/sibf_stream_if.sv
`timescale 1ns/1ns
`default_nettype none
// carries a byte stream between front end and fifo
interface sibf_stream_if #(parameter int W = 8);
    logic valid; // source holds a word
    logic ready; // sink can take it
    logic [W-1:0] data; // the word
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : sibf_stream_if
`default_nettype wire

// file: src/sibf_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module sibf_fifo
    import sibf_pkg::*;
#(
    parameter int WIDTH = SIBF_FIFO_WIDTH,
    parameter int DEPTH = SIBF_FIFO_DEPTH
) (
    input wire logic mclk,
    input wire logic nrst,
    sibf_stream_if.snk wr,
    sibf_stream_if.src rd
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH]; // storage, no reset needed
    logic [AW-1:0] wp_q, wp_d, rp_q, rp_d; // pointers
    logic [AW:0] cnt_q, cnt_d; // occupancy
    logic push, pop;
    // honest full and empty from the count; the depth is cut to the
    // count's width, since a pointer-wide cast of a power of two is zero
    assign wr.ready = (cnt_q != (AW+1)'(DEPTH));
    assign rd.valid = (cnt_q != '0);
    assign rd.data = mem[rp_q];
    assign push = wr.valid && wr.ready;
    assign pop = rd.valid && rd.ready;
    // pointer and count next values
    always_comb begin
        wp_d = wp_q;
        rp_d = rp_q;
        cnt_d = cnt_q;
        if (push) begin
            wp_d = (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
        end
        if (pop) begin
            rp_d = (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
        end
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
    // register pointers, write storage
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
            cnt_q <= cnt_d;
        end
        if (push) begin
            mem[wp_q] <= wr.data;
        end
    end
endmodule : sibf_fifo
`default_nettype wire

// file: tb/sibf_chk.sv
`timescale 1ns/1ns
`default_nettype none
// pin and status watcher for the front end
module sibf_chk (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic scl_i,
    input wire logic scl_o,
    input wire logic scl_oe,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe,
    input wire logic bus_busy,
    input wire logic dev_ready,
    input wire logic sleeping,
    input wire logic start_seen,
    input wire logic stop_seen
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    a_clk_pad_idle: assert property (!scl_oe && !scl_o)
        else $error("clock pad driven");
    a_data_low_only: assert property (sda_oe |-> !sda_o)
        else $error("data pad driven high");
    a_start_busy: assert property (start_seen |=> bus_busy)
        else $error("start left bus free");
    a_stop_free: assert property (stop_seen |=> !bus_busy)
        else $error("stop left bus busy");
    // pins settle four cycles around each condition, so a window is safe
    a_start_shape: assert property (start_seen |->
        scl_i && !sda_i && $past(sda_i, 4))
        else $error("start without data fall under high clock");
    a_stop_shape: assert property (stop_seen |->
        scl_i && sda_i && !$past(sda_i, 4))
        else $error("stop without data rise under high clock");
    a_quiet_early: assert property (!dev_ready |->
        !sda_oe && !bus_busy && !start_seen)
        else $error("activity before power-up delay");
    a_busy_awake: assert property (bus_busy |-> !sleeping)
        else $error("asleep while bus busy");
    a_idle_released: assert property (sleeping |-> !sda_oe)
        else $error("data pad held while asleep");
    a_sleep_after: assert property ($fell(bus_busy) |-> ##[0:3] sleeping)
        else $error("no sleep after stop");
    a_oe_clk_low: assert property ($changed(sda_oe) |-> !scl_i)
        else $error("data pad moved while clock high");
endmodule : sibf_chk
`default_nettype wire

// file: tb/sibf_host.sv
`timescale 1ns/1ns
`default_nettype none
// bus controller model: only pulls lines low, pull-ups make the high
module sibf_host (
    input wire logic mclk,
    input wire logic sda,
    output logic scl_oe,
    output logic sda_oe
);
    initial begin
        scl_oe = 1'b0; // clock stands high between frames
        sda_oe = 1'b0;
    end
    // one bit, 64 ns: data moves a cycle after the clock fall
    task automatic h_bit(input logic b, output logic r);
        @(negedge mclk);
        sda_oe = !b;
        repeat (4) @(negedge mclk);
        scl_oe = 1'b0;
        repeat (2) @(negedge mclk);
        r = sda;
        @(negedge mclk);
        scl_oe = 1'b1;
    endtask : h_bit
    // data falls while the clock is high; from a held-low clock both
    // lines are released first, which makes a repeated start
    task automatic h_start();
        @(negedge mclk);
        sda_oe = 1'b0;
        repeat (4) @(negedge mclk);
        scl_oe = 1'b0;
        repeat (4) @(negedge mclk);
        sda_oe = 1'b1;
        repeat (4) @(negedge mclk);
        scl_oe = 1'b1;
    endtask : h_start
    // data rises while the clock is high, then all released
    task automatic h_stop();
        @(negedge mclk);
        sda_oe = 1'b1;
        repeat (4) @(negedge mclk);
        scl_oe = 1'b0;
        repeat (4) @(negedge mclk);
        sda_oe = 1'b0;
        repeat (4) @(negedge mclk);
    endtask : h_stop
    // msb first, then the ninth bit b9 is driven and seen
    task automatic h_byte(input logic [7:0] d, input logic b9,
                          output logic [7:0] q, output logic r9);
        for (int i = 7; i >= 0; i--) begin
            h_bit(d[i], q[i]);
        end
        h_bit(b9, r9);
    endtask : h_byte
endmodule : sibf_host
`default_nettype wire

// file: tb/sibf_frontend_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module sibf_frontend_tb_top;
    import sibf_pkg::*;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic rx_ready = 1'b0; // far side stalls until the drain
    logic [7:0] tx_data = 8'h00;
    logic tx_valid = 1'b0;
    logic h_scl_oe, h_sda_oe, scl_oe, sda_oe, scl_o, sda_o, r9;
    logic rx_valid, tx_ready, bus_busy, dev_ready, sleeping;
    logic start_seen, stop_seen;
    logic [7:0] rx_data, q;
    int mismatches = 0;
    int total_checks = 0;
    logic [7:0] tx_takes = 8'h00; // take strobes from the front end, counted even when tx_valid is low
    // open-drain wires with pull-ups
    wire logic scl = !(h_scl_oe | scl_oe);
    wire logic sda = !(h_sda_oe | sda_oe);
    always #4 mclk = ~mclk;
    // count take pulses mid-cycle, where the strobe has settled
    always @(negedge mclk) begin
        if (tx_ready) begin
            tx_takes <= tx_takes + 8'h01;
        end
    end
    // short power-up count keeps the run brief
    sibf_frontend #(.PWRUP_CYC(50)) dut (.mclk, .nrst, .scl_i(scl),
        .scl_o, .scl_oe, .sda_i(sda), .sda_o, .sda_oe, .rx_data, .rx_valid,
        .rx_ready, .tx_data, .tx_valid, .tx_ready, .bus_busy, .dev_ready,
        .sleeping, .start_seen, .stop_seen);
    sibf_host host (.mclk, .sda, .scl_oe(h_scl_oe), .sda_oe(h_sda_oe));
    function automatic logic [7:0] pat(input int i);
        return 8'h5c ^ 8'(i * 19);
    endfunction : pat
    task automatic chk(input string n, input logic [7:0] s,
                       input logic [7:0] e);
        total_checks++;
        if (s !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : give_verdict
    // ready only after the delay with the clock high
    task automatic t_powerup();
        repeat (40) @(negedge mclk);
        chk("ready early", {7'h00, dev_ready}, 8'h00);
        repeat (20) @(negedge mclk);
        chk("ready", {7'h00, dev_ready}, 8'h01);
        chk("asleep", {7'h00, sleeping}, 8'h01);
    endtask : t_powerup
    // eight bytes fill the buffer, the ninth is refused, then drain
    task automatic t_fill();
        host.h_start();
        host.h_byte({SIBF_ADDR, 1'b0}, 1'b1, q, r9);
        chk("hdr ack", {7'h00, r9}, 8'h00);
        chk("busy", {7'h00, bus_busy}, 8'h01);
        for (int i = 0; i < 9; i++) begin
            host.h_byte(pat(i), 1'b1, q, r9);
            chk("wr ack", {7'h00, r9}, {7'h00, i == 8});
        end
        host.h_stop();
        chk("free", {7'h00, bus_busy}, 8'h00);
        rx_ready = 1'b1;
        for (int i = 0; i < 8; i++) begin
            chk("rx valid", {7'h00, rx_valid}, 8'h01);
            chk("rx data", rx_data, pat(i));
            @(negedge mclk);
        end
        chk("empty", {7'h00, rx_valid}, 8'h00);
        rx_ready = 1'b0;
    endtask : t_fill
    // another address is never answered and stores nothing; a repeated
    // start to our address is then taken without a stop in between
    task automatic t_wrong();
        host.h_start();
        host.h_byte({SIBF_ADDR ^ 7'h01, 1'b0}, 1'b1, q, r9);
        chk("bad hdr", {7'h00, r9}, 8'h01);
        host.h_byte(8'h3c, 1'b1, q, r9);
        chk("no store", {7'h00, rx_valid}, 8'h00);
        host.h_start();
        host.h_byte({SIBF_ADDR, 1'b0}, 1'b1, q, r9);
        chk("restart hdr", {7'h00, r9}, 8'h00);
        host.h_byte(8'h3c, 1'b1, q, r9);
        chk("restart ack", {7'h00, r9}, 8'h00);
        host.h_stop();
        chk("restart data", rx_data, 8'h3c);
        rx_ready = 1'b1;
        @(negedge mclk);
        rx_ready = 1'b0;
        chk("restart pop", {7'h00, rx_valid}, 8'h00);
    endtask : t_wrong
    // read one byte, then an empty slot gives all ones
    task automatic t_read();
        tx_data = 8'ha5;
        tx_valid = 1'b1;
        host.h_start();
        host.h_byte({SIBF_ADDR, SIBF_DIR_READ}, 1'b1, q, r9);
        chk("rd hdr", {7'h00, r9}, 8'h00);
        // clock parked low for a long while before the data phase
        repeat (100) @(negedge mclk);
        host.h_byte(8'hff, 1'b0, q, r9);
        chk("rd byte", q, 8'ha5);
        tx_valid = 1'b0;
        host.h_byte(8'hff, 1'b1, q, r9);
        chk("rd none", q, 8'hff);
        chk("tx takes", tx_takes, 8'h02);
        host.h_stop();
        chk("sleep", {7'h00, sleeping}, 8'h01);
    endtask : t_read
    initial begin
        repeat (2) @(negedge mclk);
        nrst = 1'b1;
        t_powerup();
        t_fill();
        t_wrong();
        t_read();
        give_verdict();
    end
    // generous bound: the whole run needs about 1500 cycles
    initial begin
        #100000;
        mismatches++;
        give_verdict();
    end
endmodule : sibf_frontend_tb_top
bind sibf_frontend sibf_chk u_chk (.mclk, .nrst, .scl_i, .scl_o, .scl_oe,
    .sda_i, .sda_o, .sda_oe, .bus_busy, .dev_ready, .sleeping, .start_seen,
    .stop_seen);
`default_nettype wire
